// ==== ttmd_defines.svh ====
`ifndef TTMD_DEFINES_SVH
`define TTMD_DEFINES_SVH
// Summary of operation
// - Every instruction word has one move slot per bus, driving only that bus.
// - A unit starts an operation only when an operand lands on its trigger port.
// - Unit ports are registers, so results bypass straight between units.
// - A short-immediate move takes its value from the slot source field.
// - The instruction template marks each slot as a move or a long-constant piece.
// - A slot carrying a long-constant piece moves nothing on its bus.
// - The decoder assembles the long constant into the immediate register named by the header index field.
// - The immediate unit is read-only to the datapath; only the decoder writes it.
// - Each operand is bound to one fixed unit port, addressed by moves.
// - A single-operand operation arrives on the trigger port and starts there.
// - Units have NI inputs and NO outputs, at most 4 each through the 2-bit port field; the model unit has a one-cycle depth.
// - Narrow operand ports may be narrower than the data width.

// ----------------------------------------
// Slot layout
// ----------------------------------------
`define TTMD_SLOT_W 16
`define TTMD_SRC_W 7
`define TTMD_DST_W 8
`define TTMD_UNIT_W 3
`define TTMD_PORT_W 2
`define TTMD_OPC_W 3
`define TTMD_SRC_UNIT_POS 4
`define TTMD_SRC_PORT_POS 2

// ----------------------------------------
// Instruction header above the slots
// ----------------------------------------
`define TTMD_TMPL_W 2
`define TTMD_IUIDX_W 2
`define TTMD_HDR_W 4

// ----------------------------------------
// Port roles and unit codes
// ----------------------------------------
`define TTMD_TRIG_PORT 0
`define TTMD_NARROW_PORT 1
`define TTMD_IMM_UNIT 3'h7
`define TTMD_RST_DATA 32'h0000_0000
`endif

// ==== ttmd_pkg.sv ====
package ttmd_pkg;
`include "ttmd_defines.svh"

	typedef struct packed {
		logic [`TTMD_UNIT_W-1:0] unit;
		logic [`TTMD_PORT_W-1:0] port;
		logic [`TTMD_OPC_W-1:0] opc;
	} ttmd_dst_t;

	typedef struct packed {
		logic imm;
		logic [`TTMD_SRC_W-1:0] src;
		ttmd_dst_t dst;
	} ttmd_slot_t;
endpackage

// ==== ttmd_decoder.sv ====
`timescale 1ns/1ps
`include "ttmd_defines.svh"
module ttmd_decoder import ttmd_pkg::*; #(
	parameter int NB = 3,
	parameter int NU = 4,
	parameter int NI = 3,
	parameter int NO = 2,
	parameter int DW = 32,
	parameter int NARROW_W = 16
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic instr_valid_i,
	input wire logic [`TTMD_HDR_W+NB*`TTMD_SLOT_W-1:0] instr_i,
	input wire logic [NU-1:0][NO-1:0][DW-1:0] fu_out_i,
	output logic [NB-1:0] bus_act_o,
	output logic [NB-1:0][DW-1:0] bus_data_o,
	output logic [NU-1:0][NI-1:0][DW-1:0] op_o,
	output logic [NU-1:0] trig_o,
	output logic [NU-1:0][`TTMD_OPC_W-1:0] opc_o
);
	localparam int IW = `TTMD_HDR_W + NB * `TTMD_SLOT_W;
	localparam int IU_N = 1 << `TTMD_IUIDX_W;
	localparam int SW = `TTMD_SLOT_W;

	// ----------------------------------------
	// Instruction split
	// ----------------------------------------
	logic [`TTMD_TMPL_W-1:0] tmpl;
	logic [`TTMD_IUIDX_W-1:0] iu_idx;
	ttmd_slot_t [NB-1:0] slot;
	logic [NB-1:0] limm_mask;
	logic [NB-1:0] mv_en;
	logic limm_ld;
	logic [DW-1:0] limm_val;
	logic [NB*SW-1:0] limm_acc;
	logic [NB-1:0][DW-1:0] bus_val;
	logic [NU-1:0][NI-1:0] hit;
	logic [NU-1:0][NI-1:0][DW-1:0] hit_val;
	logic [NU-1:0] trig_hit;
	logic [NU-1:0][`TTMD_OPC_W-1:0] trig_opc;

	logic [NB-1:0] bus_act_reg;
	logic [NB-1:0][DW-1:0] bus_data_reg;
	logic [NU-1:0][NI-1:0][DW-1:0] op_reg;
	logic [NU-1:0] trig_reg;
	logic [NU-1:0][`TTMD_OPC_W-1:0] opc_reg;
	logic [IU_N-1:0][DW-1:0] limm_reg;

	assign tmpl = instr_i[IW-1 -: `TTMD_TMPL_W];
	assign iu_idx = instr_i[IW-`TTMD_TMPL_W-1 -: `TTMD_IUIDX_W];
	assign slot = instr_i[NB*SW-1:0];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Template t hands the top t slots to the long constant
	function automatic logic [NB-1:0] tmpl_mask(input logic [`TTMD_TMPL_W-1:0] t);
		logic [NB-1:0] m;
		m = '0;
		for (int b = 0; b < NB; b++) begin
			m[b] = (b >= NB - int'(t));
		end
		return m;
	endfunction

	function automatic logic [DW-1:0] sext_short(input logic [`TTMD_SRC_W-1:0] s);
		return {{(DW-`TTMD_SRC_W){s[`TTMD_SRC_W-1]}}, s};
	endfunction

	// Out-of-range sources read zero rather than wrapping onto another unit
	function automatic logic [DW-1:0] read_src(input logic [`TTMD_SRC_W-1:0] s);
		logic [`TTMD_UNIT_W-1:0] u;
		logic [`TTMD_PORT_W-1:0] p;
		u = s[`TTMD_SRC_UNIT_POS +: `TTMD_UNIT_W];
		p = s[`TTMD_SRC_PORT_POS +: `TTMD_PORT_W];
		if (u == `TTMD_IMM_UNIT) begin
			return limm_reg[p];
		end else if (int'(u) < NU && int'(p) < NO) begin
			return fu_out_i[u][p];
		end else begin
			return '0;
		end
	endfunction

	// Narrow port keeps only its low bits; upper flops stay zero
	function automatic logic [DW-1:0] port_fit(input int p, input logic [DW-1:0] v);
		if (p == `TTMD_NARROW_PORT) begin
			return {{(DW-NARROW_W){1'b0}}, v[NARROW_W-1:0]};
		end
		return v;
	endfunction

	// ----------------------------------------
	// Template and long constant
	// ----------------------------------------
	assign limm_mask = tmpl_mask(tmpl);
	assign mv_en = {NB{instr_valid_i}} & ~limm_mask;
	assign limm_ld = instr_valid_i & (|limm_mask);

	// Pieces pack low slot first into consecutive fields
	always_comb begin
		int k;
		k = 0;
		limm_acc = '0;
		for (int b = 0; b < NB; b++) begin
			if (limm_mask[b]) begin
				limm_acc[k*SW +: SW] = slot[b];
				k++;
			end
		end
		limm_val = DW'(limm_acc);
	end

	// ----------------------------------------
	// Bus sources
	// ----------------------------------------
	always_comb begin
		for (int b = 0; b < NB; b++) begin
			if (slot[b].imm) begin
				bus_val[b] = sext_short(slot[b].src);
			end else begin
				bus_val[b] = read_src(slot[b].src);
			end
		end
	end

	// ----------------------------------------
	// Destination decode
	// ----------------------------------------
	// Two buses aiming at one port is a scheduling fault; the higher bus wins
	always_comb begin
		for (int u = 0; u < NU; u++) begin
			trig_opc[u] = '0;
			for (int p = 0; p < NI; p++) begin
				hit[u][p] = 1'b0;
				hit_val[u][p] = '0;
				for (int b = 0; b < NB; b++) begin
					if (mv_en[b] && slot[b].dst.unit == `TTMD_UNIT_W'(u)
						&& slot[b].dst.port == `TTMD_PORT_W'(p)) begin
						hit[u][p] = 1'b1;
						hit_val[u][p] = port_fit(p, bus_val[b]);
						if (p == `TTMD_TRIG_PORT) begin
							trig_opc[u] = slot[b].dst.opc;
						end
					end
				end
			end
			trig_hit[u] = hit[u][`TTMD_TRIG_PORT];
		end
	end

	// ----------------------------------------
	// Bus transport
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			bus_act_reg <= '0;
			bus_data_reg <= '0;
		end else begin
			bus_act_reg <= mv_en;
			bus_data_reg <= bus_val;
		end
	end

	// ----------------------------------------
	// Unit input port registers
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			op_reg <= '0;
		end else begin
			for (int u = 0; u < NU; u++) begin
				for (int p = 0; p < NI; p++) begin
					if (hit[u][p]) begin
						op_reg[u][p] <= hit_val[u][p];
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Triggers
	// ----------------------------------------
	// The pulse aligns with the trigger operand appearing at the port
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			trig_reg <= '0;
			opc_reg <= '0;
		end else begin
			trig_reg <= trig_hit;
			for (int u = 0; u < NU; u++) begin
				if (trig_hit[u]) begin
					opc_reg[u] <= trig_opc[u];
				end
			end
		end
	end

	// ----------------------------------------
	// Immediate unit
	// ----------------------------------------
	// No bus path writes here, so the datapath sees it read-only
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			limm_reg <= {IU_N{`TTMD_RST_DATA}};
		end else if (limm_ld) begin
			limm_reg[iu_idx] <= limm_val;
		end
	end

	assign bus_act_o = bus_act_reg;
	assign bus_data_o = bus_data_reg;
	assign op_o = op_reg;
	assign trig_o = trig_reg;
	assign opc_o = opc_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_bus_move;
		@(posedge mclk_i) disable iff (sys_rst_i)
		instr_valid_i && !limm_mask[0] |=> bus_act_o[0] && bus_data_o[0] == $past(bus_val[0]);
	endproperty
	a_bus_move: assert property (p_bus_move) else $error("bus 0 move lost");

	property p_trig_cause;
		@(posedge mclk_i) disable iff (sys_rst_i)
		trig_o[0] |-> $past(instr_valid_i) && $past(hit[0][`TTMD_TRIG_PORT]);
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger without move");

	property p_short;
		@(posedge mclk_i) disable iff (sys_rst_i)
		instr_valid_i && !limm_mask[0] && slot[0].imm
		|=> bus_data_o[0] == sext_short($past(slot[0].src));
	endproperty
	a_short: assert property (p_short) else $error("short immediate wrong");

	property p_limm_idle;
		@(posedge mclk_i) disable iff (sys_rst_i)
		instr_valid_i && tmpl != '0 |=> !bus_act_o[NB-1];
	endproperty
	a_limm_idle: assert property (p_limm_idle) else $error("constant slot moved");

	property p_limm_write;
		@(posedge mclk_i) disable iff (sys_rst_i)
		limm_ld |=> limm_reg[$past(iu_idx)] == $past(limm_val);
	endproperty
	a_limm_write: assert property (p_limm_write) else $error("long constant not stored");

	property p_limm_hold;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!limm_ld |=> $stable(limm_reg);
	endproperty
	a_limm_hold: assert property (p_limm_hold) else $error("immediate unit changed");

	property p_bind;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!(|hit[0]) |=> $stable(op_o[0]);
	endproperty
	a_bind: assert property (p_bind) else $error("unaddressed port changed");

	property p_narrow;
		@(posedge mclk_i) disable iff (sys_rst_i)
		op_o[0][`TTMD_NARROW_PORT][DW-1:NARROW_W] == '0;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow port upper bits set");

	property p_opc;
		@(posedge mclk_i) disable iff (sys_rst_i)
		trig_hit[0] |=> trig_o[0] && opc_o[0] == $past(trig_opc[0]);
	endproperty
	a_opc: assert property (p_opc) else $error("selector not delivered");

	property p_idle_bus;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!instr_valid_i |=> bus_act_o == '0;
	endproperty
	a_idle_bus: assert property (p_idle_bus) else $error("bus moved while idle");

	property p_idle_trig;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!instr_valid_i |=> trig_o == '0;
	endproperty
	a_idle_trig: assert property (p_idle_trig) else $error("trigger while idle");

	property p_port_reg;
		@(posedge mclk_i) disable iff (sys_rst_i)
		hit[0][`TTMD_TRIG_PORT]
		|=> op_o[0][`TTMD_TRIG_PORT] == $past(hit_val[0][`TTMD_TRIG_PORT]);
	endproperty
	a_port_reg: assert property (p_port_reg) else $error("port register not loaded");

	property p_all_moves;
		@(posedge mclk_i) disable iff (sys_rst_i)
		instr_valid_i && tmpl == '0 |=> &bus_act_o;
	endproperty
	a_all_moves: assert property (p_all_moves) else $error("move slot lost");

	property p_all_const;
		@(posedge mclk_i) disable iff (sys_rst_i)
		instr_valid_i && int'(tmpl) >= NB |=> bus_act_o == '0;
	endproperty
	a_all_const: assert property (p_all_const) else $error("constant slots moved");

	property p_opc_hold;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!trig_hit[0] |=> $stable(opc_o[0]);
	endproperty
	a_opc_hold: assert property (p_opc_hold) else $error("selector changed alone");
endmodule // ttmd_decoder

// ==== ttmd_fu_model.sv ====
`timescale 1ns/1ps
module ttmd_fu_model import ttmd_pkg::*; #(
	parameter int NU = 4,
	parameter int NI = 3,
	parameter int NO = 2,
	parameter int DW = 32
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [NU-1:0][NI-1:0][DW-1:0] op_i,
	input wire logic [NU-1:0] trig_i,
	input wire logic [NU-1:0][2:0] opc_i,
	output logic [NU-1:0][NO-1:0][DW-1:0] fu_out_o
);
	// ----------------------------------------
	// Result registers
	// ----------------------------------------
	// Results land one edge after the trigger, never combinationally
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			fu_out_o <= '0;
		end else begin
			for (int u = 0; u < NU; u++) begin
				if (trig_i[u]) begin
					fu_out_o[u][0] <= op_i[u][0] + op_i[u][1] + DW'(opc_i[u]);
					fu_out_o[u][1] <= ~op_i[u][0];
				end
			end
		end
	end
endmodule // ttmd_fu_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top import ttmd_pkg::*;;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic instr_valid_i = 1'b0;
	logic [51:0] instr_i = '0;
	logic [3:0][1:0][31:0] fu_out;
	logic [2:0] bus_act;
	logic [2:0][31:0] bus_data;
	logic [3:0][2:0][31:0] op;
	logic [3:0] trig;
	logic [3:0][2:0] opc;
	int fail_count = 0;
	int samples_checked = 0;
	always #4 mclk_i = ~mclk_i;
	ttmd_decoder ttmd_decoder_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .fu_out_i(fu_out),
		.bus_act_o(bus_act), .bus_data_o(bus_data), .op_o(op), .trig_o(trig), .opc_o(opc));
	ttmd_fu_model ttmd_fu_model_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.op_i(op), .trig_i(trig), .opc_i(opc), .fu_out_o(fu_out));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic ttmd_slot_t sl(logic i, logic [6:0] s, logic [2:0] u, logic [1:0] p,
		logic [2:0] o);
		return {i, s, u, p, o};
	endfunction
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic issue(logic [1:0] t, logic [1:0] ix, logic [15:0] s2, s1, s0);
		instr_i = {t, ix, s2, s1, s0};
		instr_valid_i = 1'b1;
		@(posedge mclk_i);
		#1;
	endtask
	// Upper slots go to scratch constant reg 3 so no stray move disturbs a check
	task automatic mv(logic [15:0] s0);
		issue(2'h2, 2'h3, 16'h0000, 16'h0000, s0);
	endtask
	task automatic idle();
		instr_valid_i = 1'b0;
		@(posedge mclk_i);
		#1;
	endtask
	task automatic print_verdict();
		$display("counts: %0d checked, %0d bad", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_short();
		mv(sl(1'b1, 7'h7f, 3'h0, 2'h0, 3'h3));
		chk(bus_act, 32'h1);
		chk(bus_data[0], 32'hffffffff);
		chk(op[0][0], 32'hffffffff);
		chk(trig, 32'h1);
		chk(opc[0], 32'h3);
		idle();
		chk(trig, 32'h0);
		chk(op[0][0], 32'hffffffff);
		$display("test short done");
	endtask
	task automatic t_parallel();
		issue(2'h0, 2'h0, sl(1'b1, 7'h03, 3'h2, 2'h2, 3'h0), sl(1'b1, 7'h02, 3'h1, 2'h2, 3'h0),
			sl(1'b1, 7'h01, 3'h0, 2'h2, 3'h0));
		chk(bus_act, 32'h7);
		chk(op[0][2], 32'h1);
		chk(op[2][2], 32'h3);
		chk(trig, 32'h0);
		chk(bus_data[2], 32'h3);
		// Absent units and ports: sources read zero, moves are dropped
		issue(2'h0, 2'h0, sl(1'b0, 7'h5c, 3'h4, 2'h0, 3'h0), sl(1'b0, 7'h0c, 3'h0, 2'h3, 3'h0),
			sl(1'b1, 7'h05, 3'h6, 2'h0, 3'h0));
		chk(bus_act, 32'h7);
		chk(bus_data[0], 32'h5);
		chk(bus_data[1], 32'h0);
		chk(bus_data[2], 32'h0);
		chk(trig, 32'h0);
		chk(op[0][0], 32'hffffffff);
		idle();
		$display("test parallel done");
	endtask
	task automatic t_long();
		// Same instruction reads reg 1 before its own write lands
		issue(2'h2, 2'h1, 16'h1234, 16'h5678, sl(1'b0, 7'h74, 3'h2, 2'h1, 3'h0));
		chk(bus_act, 32'h1);
		chk(bus_data[0], 32'h0);
		mv(sl(1'b0, 7'h74, 3'h2, 2'h0, 3'h1));
		chk(bus_data[0], 32'h12345678);
		chk(op[2][0], 32'h12345678);
		chk(trig, 32'h4);
		chk(opc[2], 32'h1);
		issue(2'h3, 2'h2, 16'hbeef, 16'h0c01, 16'h0003);
		chk(bus_act, 32'h0);
		chk(trig, 32'h0);
		mv(sl(1'b0, 7'h78, 3'h3, 2'h1, 3'h0));
		chk(bus_data[0], 32'h0c010003);
		idle();
		$display("test long done");
	endtask
	task automatic t_bypass();
		mv(sl(1'b1, 7'h7f, 3'h1, 2'h1, 3'h0));
		chk(op[1][1], 32'h0000ffff);
		chk(trig, 32'h0);
		mv(sl(1'b1, 7'h02, 3'h1, 2'h0, 3'h2));
		chk(trig, 32'h2);
		chk(opc[1], 32'h2);
		idle();
		issue(2'h1, 2'h3, 16'h0000, sl(1'b0, 7'h14, 3'h0, 2'h1, 3'h0),
			sl(1'b0, 7'h10, 3'h3, 2'h0, 3'h0));
		chk(bus_act, 32'h3);
		chk(op[3][0], 32'h00010003);
		chk(op[0][1], 32'h0000fffd);
		chk(trig, 32'h8);
		idle();
		$display("test bypass done");
	endtask
	initial begin
		repeat (20) @(posedge mclk_i);
		#1;
		sys_rst_i = 1'b0;
		chk(bus_act, 32'h0);
		chk(trig, 32'h0);
		chk(op[0][0], 32'h0);
		t_short();
		t_parallel();
		t_long();
		t_bypass();
		print_verdict();
	end
	// Whole run is under 60 cycles, so 500 means a hang
	initial begin
		repeat (500) @(posedge mclk_i);
		fail_count++;
		$display("BAD %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule // tb_top
